// ---- tpsf_pkg.sv ----
// Shared constants and types for the test path and supply fault block
package tpsf_pkg;
	// Register port and measurement value widths
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int VAL_W  = 16;

	// Register offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_PATH = 4'h1;
	localparam logic [3:0] OFS_FLAG = 4'h2;
	localparam logic [3:0] OFS_MASK = 4'h3;
	localparam logic [3:0] OFS_RAW  = 4'h4;

	// Control register fields
	localparam int CTRL_W    = 3;
	localparam int CTRL_EN   = 0;
	localparam int CTRL_TEMP = 1;
	localparam int CTRL_AUTO = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;

	// Path status fields
	localparam int PATH_W      = 3;
	localparam int PATH_ALT    = 0;
	localparam int PATH_TEMP   = 1;
	localparam int PATH_ONCE   = 2;

	// Sticky flag and mask fields
	localparam int FLAG_W      = 5;
	localparam int NUM_REG     = 3;
	localparam int FLG_SUPPLY  = 3;
	localparam int FLG_RETURN  = 4;
	localparam logic [4:0] FLAG_RST = 5'h00;
	localparam logic [4:0] MASK_RST = 5'h00;

	// Comparator sources: three regulators, then supply checks
	localparam int NUM_SRC     = 6;
	localparam int SRC_VDD_OV  = 3;
	localparam int SRC_GND_OFF = 4;
	localparam int SRC_VDD_OFF = 5;

	// Spike filter timing
	localparam int CLK_PERIOD_NS       = 50;
	localparam int FILTER_DELAY_NS     = 10000;
	localparam int FILTER_MIN_CLOCKS   = 256;
	localparam int FILTER_TIME_CLOCKS  = (FILTER_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILTER_CYCLES       = (FILTER_TIME_CLOCKS > FILTER_MIN_CLOCKS) ?
		FILTER_TIME_CLOCKS : FILTER_MIN_CLOCKS;
	localparam int CNT_W               = $clog2(FILTER_CYCLES + 1);

	// Output path states
	typedef enum logic [1:0] {
		PATH_NORMAL,
		PATH_HELD,
		PATH_ONESHOT
	} tpsf_path_t;
endpackage

// ---- tpsf_sync3.sv ----
// Three-stage synchroniser with agreement check for comparator levels
`timescale 1ns/1ps
module tpsf_sync3 (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic async_i,
	output logic      level_o
);
	logic s1_q;    // First stage, feeds only s2
	logic s2_q;    // Second stage
	logic s3_q;    // Third stage
	logic level_q; // Accepted level

	// Shift chain
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Change counts once stages two and three agree
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			level_q <= 1'b0;
		end else if (s2_q == s3_q) begin
			level_q <= s3_q;
		end
	end

	assign level_o = level_q;
endmodule

// ---- tpsf_spike_filter.sv ----
// Digital spike filter: fires after a level persists long enough
`timescale 1ns/1ps
module tpsf_spike_filter (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic level_i,
	output logic      hit_o
);
	localparam logic [tpsf_pkg::CNT_W-1:0] LAST = tpsf_pkg::CNT_W'(tpsf_pkg::FILTER_CYCLES);
	localparam logic [tpsf_pkg::CNT_W-1:0] ONE  = tpsf_pkg::CNT_W'(1);
	localparam logic [tpsf_pkg::CNT_W-1:0] ZERO = tpsf_pkg::CNT_W'(0);

	logic [tpsf_pkg::CNT_W-1:0] cnt_q; // Consecutive high cycles, saturating
	logic [tpsf_pkg::CNT_W-1:0] cnt_d;

	// Restart on any drop, count while high, hold at the end
	assign cnt_d = !level_i ? ZERO : ((cnt_q == LAST) ? LAST : cnt_q + ONE); // [RULE4] [RULE11]

	// Counter register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= ZERO;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Fault accepted only after the full delay
	assign hit_o = (cnt_q == LAST); // [RULE4]

	a_count_restart: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
		!level_i |=> (cnt_q == ZERO) && !hit_o)
		else $error("filter count did not restart after drop");

	a_fire_after_delay: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
		$rose(hit_o) |-> $past(level_i, 1) && $past(level_i, 8) && ($past(cnt_q) == LAST - ONE))
		else $error("filter fired before full delay");
endmodule

// ---- tpsf_top.sv ----
// Test path selection and supply fault status for the angle sensor
// Overview of operation
// RULE1: Angle test and temperature share one path switch.
// RULE2: Normal Mode holds alternate source until ended.
// RULE3: Automatic Mode returns after one value read.
// RULE4: Fault sets flag after 256-cycle continuous persistence.
// RULE5: Each regulator overvoltage sets its own flag.
// RULE6: Filtered supply overvoltage sets supply fault flag.
// RULE7: Filtered ground loss sets supply fault flag.
// RULE8: Filtered supply loss sets supply fault flag.
// RULE9: Clock spikes above supply also flag supply loss.
// RULE10: Temperature value goes out in X slot.
// RULE11: Filter count restarts when comparator drops early.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module tpsf_top (
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	// Register port
	input  wire logic [tpsf_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [tpsf_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [tpsf_pkg::DATA_W-1:0]  reg_rdata,
	output logic                              irq,
	// Analog comparator outputs
	input  wire logic                         reg_ov_g_cmp,
	input  wire logic                         reg_ov_a_cmp,
	input  wire logic                         reg_ov_d_cmp,
	input  wire logic                         vdd_ov_cmp,
	input  wire logic                         gnd_off_cmp,
	input  wire logic                         vdd_off_cmp,
	// Measurement sources and readout strobe
	input  wire logic                         value_read,
	input  wire logic [tpsf_pkg::VAL_W-1:0]   field_x,
	input  wire logic [tpsf_pkg::VAL_W-1:0]   field_y,
	input  wire logic [tpsf_pkg::VAL_W-1:0]   test_x,
	input  wire logic [tpsf_pkg::VAL_W-1:0]   test_y,
	input  wire logic [tpsf_pkg::VAL_W-1:0]   temp_value,
	// Output path and status
	output logic      [tpsf_pkg::VAL_W-1:0]   out_x,
	output logic      [tpsf_pkg::VAL_W-1:0]   out_y,
	output logic                              path_alt,
	output logic      [tpsf_pkg::NUM_REG-1:0] regulator_overvoltage_flag,
	output logic                              supply_fault_flag
);
	// Registers
	logic [tpsf_pkg::CTRL_W-1:0] ctrl_q;     // Source select and mode
	logic [tpsf_pkg::CTRL_W-1:0] ctrl_d;
	logic [tpsf_pkg::FLAG_W-1:0] mask_q;     // Interrupt mask
	logic [tpsf_pkg::FLAG_W-1:0] mask_d;
	logic [tpsf_pkg::FLAG_W-1:0] flag_q;     // Sticky event flags
	logic [tpsf_pkg::FLAG_W-1:0] flag_d;
	tpsf_pkg::tpsf_path_t        state_q;    // Output path state
	tpsf_pkg::tpsf_path_t        state_d;
	logic [tpsf_pkg::VAL_W-1:0]  out_x_q;    // Registered X slot
	logic [tpsf_pkg::VAL_W-1:0]  out_y_q;    // Registered Y slot
	logic                        path_alt_q; // Alternate source on output
	logic [tpsf_pkg::DATA_W-1:0] rdata_q;    // Read data
	logic                        irq_q;      // Interrupt level

	// Decode
	logic                        wr_ctrl;    // Write to control
	logic                        wr_flag;    // Write-one-to-clear
	logic                        wr_mask;    // Write to mask
	logic                        arm;        // Control write with enable
	logic                        stop;       // Control write without enable
	logic                        wr_auto;    // Mode bit on control write
	logic                        once_done;  // One value read in automatic mode
	logic                        use_alt;    // Alternate source selected
	logic                        use_temp;   // Temperature chosen
	logic [tpsf_pkg::VAL_W-1:0]  alt_x;      // Alternate X value
	logic [tpsf_pkg::VAL_W-1:0]  alt_y;      // Alternate Y value
	logic [tpsf_pkg::VAL_W-1:0]  path_x;     // Selected X value
	logic [tpsf_pkg::VAL_W-1:0]  path_y;     // Selected Y value
	logic [tpsf_pkg::FLAG_W-1:0] w1c;        // Bits to clear
	logic [tpsf_pkg::FLAG_W-1:0] set_vec;    // Bits to set
	logic [tpsf_pkg::PATH_W-1:0] path_stat;  // Path status word
	logic [tpsf_pkg::DATA_W-1:0] rd_mux;     // Read selection

	// Comparator chain
	logic [tpsf_pkg::NUM_SRC-1:0] cmp_raw;   // Asynchronous comparator levels
	logic [tpsf_pkg::NUM_SRC-1:0] cmp_lvl;   // Synchronised levels
	logic [tpsf_pkg::NUM_SRC-1:0] cmp_hit;   // Filtered fault levels
	logic                         sup_hit;   // Any supply fault source
	logic                         sup_lvl;   // Any synchronised supply level

	// Gather comparator pins
	assign cmp_raw = {vdd_off_cmp, gnd_off_cmp, vdd_ov_cmp,
		reg_ov_d_cmp, reg_ov_a_cmp, reg_ov_g_cmp};

	// Analog levels are free running, so each passes the synchroniser first
	// One synchroniser and one spike filter per source
	genvar gi;
	generate
		for (gi = 0; gi < tpsf_pkg::NUM_SRC; gi++) begin : g_src
			// Level from the analog side
			tpsf_sync3 u_sync (
				.clk     (clk),
				.sys_rst (sys_rst),
				.async_i (cmp_raw[gi]),
				.level_o (cmp_lvl[gi])
			);
			// Persistence check per source
			tpsf_spike_filter u_filt ( // [RULE4] [RULE11]
				.clk     (clk),
				.sys_rst (sys_rst),
				.level_i (cmp_lvl[gi]),
				.hit_o   (cmp_hit[gi])
			);
		end
	endgenerate

	// Supply fault sources share one flag
	assign sup_hit = cmp_hit[tpsf_pkg::SRC_VDD_OV]  // [RULE6]
		| cmp_hit[tpsf_pkg::SRC_GND_OFF]            // [RULE7]
		| cmp_hit[tpsf_pkg::SRC_VDD_OFF];           // [RULE8] [RULE9]

	// Any supply comparator level, before filtering
	assign sup_lvl = cmp_lvl[tpsf_pkg::SRC_VDD_OV] | cmp_lvl[tpsf_pkg::SRC_GND_OFF]
		| cmp_lvl[tpsf_pkg::SRC_VDD_OFF];

	// Register decode
	assign wr_ctrl = reg_wr && (reg_addr == tpsf_pkg::OFS_CTRL);
	assign wr_flag = reg_wr && (reg_addr == tpsf_pkg::OFS_FLAG);
	assign wr_mask = reg_wr && (reg_addr == tpsf_pkg::OFS_MASK);
	assign arm     = wr_ctrl && reg_wdata[tpsf_pkg::CTRL_EN];
	assign stop    = wr_ctrl && !reg_wdata[tpsf_pkg::CTRL_EN];
	assign wr_auto = reg_wdata[tpsf_pkg::CTRL_AUTO];

	// Control and mask next values
	assign ctrl_d = wr_ctrl ? reg_wdata[tpsf_pkg::CTRL_W-1:0] : ctrl_q;
	assign mask_d = wr_mask ? reg_wdata[tpsf_pkg::FLAG_W-1:0] : mask_q;

	// Automatic mode finishes on the first value read out
	// A stop in the same cycle wins, so no return event is logged
	assign once_done = (state_q == tpsf_pkg::PATH_ONESHOT) && value_read && !stop; // [RULE3]

	// Path state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			tpsf_pkg::PATH_NORMAL: begin
				// Enter the mode chosen by the write
				if (arm) begin
					state_d = wr_auto ? tpsf_pkg::PATH_ONESHOT : tpsf_pkg::PATH_HELD;
				end
			end
			tpsf_pkg::PATH_HELD: begin
				// Held until software ends it
				if (stop) begin
					state_d = tpsf_pkg::PATH_NORMAL; // [RULE2]
				end else if (arm && wr_auto) begin
					state_d = tpsf_pkg::PATH_ONESHOT;
				end
			end
			tpsf_pkg::PATH_ONESHOT: begin
				// Back to field measurement after one readout
				if (stop || once_done) begin
					state_d = tpsf_pkg::PATH_NORMAL; // [RULE3]
				end else if (arm && !wr_auto) begin
					state_d = tpsf_pkg::PATH_HELD;
				end
			end
			default: begin
				state_d = tpsf_pkg::PATH_NORMAL;
			end
		endcase
	end

	// One switch serves both alternate sources
	assign use_alt  = (state_q != tpsf_pkg::PATH_NORMAL); // [RULE1] [RULE2]
	assign use_temp = ctrl_q[tpsf_pkg::CTRL_TEMP];
	assign alt_x    = use_temp ? temp_value : test_x;     // [RULE10]
	assign alt_y    = use_temp ? field_y : test_y;
	assign path_x   = use_alt ? alt_x : field_x;          // [RULE1]
	assign path_y   = use_alt ? alt_y : field_y;          // [RULE1]

	// Sticky flags: set wins over clear
	// A fault still present keeps its flag set through a clear
	assign w1c     = wr_flag ? reg_wdata[tpsf_pkg::FLAG_W-1:0] : tpsf_pkg::FLAG_RST;
	assign set_vec = {once_done, sup_hit, cmp_hit[tpsf_pkg::NUM_REG-1:0]}; // [RULE5] [RULE6]
	assign flag_d  = (flag_q & ~w1c) | set_vec;

	// Read selection, unmapped reads zero
	assign path_stat = {(state_q == tpsf_pkg::PATH_ONESHOT), use_temp, use_alt};
	assign rd_mux =
		(reg_addr == tpsf_pkg::OFS_CTRL) ? tpsf_pkg::DATA_W'(ctrl_q) :
		(reg_addr == tpsf_pkg::OFS_PATH) ? tpsf_pkg::DATA_W'(path_stat) :
		(reg_addr == tpsf_pkg::OFS_FLAG) ? tpsf_pkg::DATA_W'(flag_q) :
		(reg_addr == tpsf_pkg::OFS_MASK) ? tpsf_pkg::DATA_W'(mask_q) :
		(reg_addr == tpsf_pkg::OFS_RAW)  ? tpsf_pkg::DATA_W'(cmp_hit) :
		tpsf_pkg::DATA_W'(0);

	// Control, mask and state registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q  <= tpsf_pkg::CTRL_RST;
			mask_q  <= tpsf_pkg::MASK_RST;
			state_q <= tpsf_pkg::PATH_NORMAL;
		end else begin
			ctrl_q  <= ctrl_d;
			mask_q  <= mask_d;
			state_q <= state_d;
		end
	end

	// Status flags
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flag_q <= tpsf_pkg::FLAG_RST;
		end else begin
			flag_q <= flag_d; // [RULE5] [RULE6] [RULE7] [RULE8]
		end
	end

	// Output path registers
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_x_q    <= tpsf_pkg::VAL_W'(0);
			out_y_q    <= tpsf_pkg::VAL_W'(0);
			path_alt_q <= 1'b0;
		end else begin
			out_x_q    <= path_x;
			out_y_q    <= path_y;
			path_alt_q <= use_alt;
		end
	end

	// Read data and interrupt
	// Interrupt uses next flag and mask so it lines up with the flags
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= tpsf_pkg::DATA_W'(0);
			irq_q   <= 1'b0;
		end else begin
			rdata_q <= reg_rd ? rd_mux : tpsf_pkg::DATA_W'(0);
			irq_q   <= |(flag_d & mask_d);
		end
	end

	// Outputs straight from registers
	assign reg_rdata                  = rdata_q;
	assign irq                        = irq_q;
	assign out_x                      = out_x_q;
	assign out_y                      = out_y_q;
	assign path_alt                   = path_alt_q;
	assign regulator_overvoltage_flag = flag_q[tpsf_pkg::NUM_REG-1:0];
	assign supply_fault_flag          = flag_q[tpsf_pkg::FLG_SUPPLY];

	// Test source reaches X and Y together
	a_shared_switch: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		(use_alt && !use_temp) |=> (out_x_q == $past(test_x)) && (out_y_q == $past(test_y)) && path_alt_q)
		else $error("test source not routed to output");

	// Normal Mode holds while no control write comes
	a_held_stays: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		(state_q == tpsf_pkg::PATH_HELD) && !wr_ctrl |=> (state_q == tpsf_pkg::PATH_HELD) ##1 path_alt_q)
		else $error("held path left without stop");

	// Automatic mode returns after one value
	a_oneshot_return: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		(state_q == tpsf_pkg::PATH_ONESHOT) && value_read && !wr_ctrl
		|=> (state_q == tpsf_pkg::PATH_NORMAL) && flag_q[tpsf_pkg::FLG_RETURN] ##1 !path_alt_q)
		else $error("automatic mode did not return");

	// Regulator fault sets its own flag
	a_reg_ov_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
		cmp_hit[tpsf_pkg::NUM_REG-1:0] != '0
		|=> (regulator_overvoltage_flag & $past(cmp_hit[tpsf_pkg::NUM_REG-1:0]))
			== $past(cmp_hit[tpsf_pkg::NUM_REG-1:0]))
		else $error("regulator flag not set");

	// Supply overvoltage sets the supply flag
	a_vdd_ov_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
		cmp_hit[tpsf_pkg::SRC_VDD_OV] |=> supply_fault_flag)
		else $error("supply overvoltage not flagged");

	// Ground loss sets the supply flag
	a_gnd_off_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
		cmp_hit[tpsf_pkg::SRC_GND_OFF] |=> supply_fault_flag)
		else $error("ground loss not flagged");

	// Supply loss or clock spike sets the supply flag
	a_vdd_off_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
		cmp_hit[tpsf_pkg::SRC_VDD_OFF] |=> supply_fault_flag)
		else $error("supply loss not flagged");

	// Supply flag rises only after a lasting level
	a_spike_ignored: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
		$rose(supply_fault_flag) |-> $past(sup_lvl, 2) && $past(sup_lvl, 8))
		else $error("supply flag set without filtered fault");

	// Temperature appears in the X slot
	a_temp_slot: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
		(use_alt && use_temp) |=> (out_x_q == $past(temp_value)) && (out_y_q == $past(field_y)))
		else $error("temperature not in X slot");

	// Interrupt follows unmasked flags
	a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
		##1 (irq_q == |(flag_q & mask_q)))
		else $error("interrupt does not match flags");

	// A stop write always returns to field measurement
	a_stop_normal: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		stop |=> (state_q == tpsf_pkg::PATH_NORMAL) ##1 !path_alt_q)
		else $error("stop write did not end the mode");

	// Enable with auto bit enters the one-shot mode
	a_arm_auto: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		arm && wr_auto && !value_read |=> (state_q == tpsf_pkg::PATH_ONESHOT))
		else $error("automatic mode not entered");

	// Enable without auto bit enters the held mode
	a_arm_held: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
		arm && !wr_auto && !value_read |=> (state_q == tpsf_pkg::PATH_HELD))
		else $error("normal mode not entered");

	// Field values pass untouched in normal measurement
	a_normal_field: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
		!sys_rst && !use_alt |=> (out_x_q == $past(field_x)) && (out_y_q == $past(field_y)) && !path_alt_q)
		else $error("field measurement not on output");

	// Return event comes only out of the one-shot mode
	a_return_source: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
		$rose(flag_q[tpsf_pkg::FLG_RETURN]) |-> ($past(state_q) == tpsf_pkg::PATH_ONESHOT))
		else $error("return event outside automatic mode");

	// Flags stay set until software clears them
	a_flag_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		!wr_flag |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
		else $error("flag dropped without a clear");

	// Writing ones clears those flags when no event is pending
	a_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
		wr_flag && (set_vec == tpsf_pkg::FLAG_RST)
		|=> ((flag_q & $past(reg_wdata[tpsf_pkg::FLAG_W-1:0])) == tpsf_pkg::FLAG_RST))
		else $error("flag not cleared by write");

	// Read data stands only in the cycle after a read
	a_read_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!reg_rd |=> (reg_rdata == tpsf_pkg::DATA_W'(0)))
		else $error("read data without a read");

	// Control read returns the written value
	a_read_ctrl: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && (reg_addr == tpsf_pkg::OFS_CTRL) |=> (reg_rdata == tpsf_pkg::DATA_W'($past(ctrl_q))))
		else $error("control read mismatch");

	// Masked flags never raise the interrupt
	a_irq_masked: assert property (@(posedge clk) disable iff (sys_rst)
		(mask_q == tpsf_pkg::MASK_RST) |-> !irq_q)
		else $error("interrupt raised with all flags masked");
endmodule

// ---- tpsf_host_model.sv ----
// Host side model: register port master and readout strobe
`timescale 1ns/1ps
module tpsf_host_model (
	input  wire logic                        clk,
	input  wire logic [tpsf_pkg::DATA_W-1:0] reg_rdata,
	output logic      [tpsf_pkg::ADDR_W-1:0] reg_addr,
	output logic      [tpsf_pkg::DATA_W-1:0] reg_wdata,
	output logic                             reg_wr,
	output logic                             reg_rd,
	output logic                             value_read
);
	// Idle bus from time zero
	initial begin
		reg_addr   = 4'h0;
		reg_wdata  = 8'h00;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		value_read = 1'b0;
	end

	// One-cycle write; always leaves an idle edge before the next strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// One-cycle read; data taken in the following cycle only
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// One value read out by the serial logic
	task automatic pulse();
		@(posedge clk);
		value_read <= 1'b1;
		@(posedge clk);
		value_read <= 1'b0;
	endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for test path selection and supply fault flags
`timescale 1ns/1ps
module tb;
	logic        clk;                     // 20 MHz clock
	logic        sys_rst;                 // Async reset
	logic [5:0]  cmp;                     // Comparators G,A,D,vddov,gndoff,vddoff
	logic [15:0] fx, fy, tx, ty, tv;      // Source values
	logic [15:0] ox, oy;                  // Output path
	logic [3:0]  addr;                    // Register address
	logic [7:0]  wdata, rdata, rv, c;     // Bus data, read value, mode
	logic        wr, rd, vread, irq, alt; // Strobes and status
	logic        sup;                     // Supply fault flag
	logic [2:0]  rov;                     // Regulator flags
	int          bad_count, total_checks; // Report counters
	int          m_flags, m_mask, n, len, b; // Model state and loop vars
	logic [7:0]  modes [4] = '{8'h01, 8'h03, 8'h05, 8'h07}; // All mode codes

	tpsf_host_model host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr), .reg_rd(rd), .value_read(vread));

	tpsf_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
		.reg_rd(rd), .reg_rdata(rdata), .irq(irq), .reg_ov_g_cmp(cmp[0]), .reg_ov_a_cmp(cmp[1]),
		.reg_ov_d_cmp(cmp[2]), .vdd_ov_cmp(cmp[3]), .gnd_off_cmp(cmp[4]), .vdd_off_cmp(cmp[5]),
		.value_read(vread), .field_x(fx), .field_y(fy), .test_x(tx), .test_y(ty),
		.temp_value(tv), .out_x(ox), .out_y(oy), .path_alt(alt),
		.regulator_overvoltage_flag(rov), .supply_fault_flag(sup));

	// Clock generator
	initial clk = 1'b0;
	always #25 clk = ~clk;

	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Output path against model after the two-cycle switch
	task automatic path_chk(input logic a, input logic t);
		repeat (3) @(posedge clk);
		#1;
		chk(16'(alt), 16'(a), "path_alt");
		chk(ox, !a ? fx : (t ? tv : tx), "out_x");
		chk(oy, (a && !t) ? ty : fy, "out_y");
	endtask

	// Hang guard
	initial begin
		#1000000;
		bad_count++;
		wrap_up();
	end

	// Main sequence
	initial begin
		cmp = 6'h00;
		fx = 16'h0000; fy = 16'h0000; tx = 16'h0000; ty = 16'h0000; tv = 16'h0000;
		sys_rst = 1'b1;
		m_flags = 0;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		void'($urandom(27));
		// Read-only and unmapped writes are ignored; all reads start at zero
		host.wr(tpsf_pkg::OFS_PATH, 8'hFF);
		host.wr(4'hF, 8'hFF);
		for (int a = 0; a < 16; a++) begin
			host.rd(4'(a), rv);
			chk(16'(rv), 16'h0000, "reset read");
		end
		chk(16'({alt, irq}), 16'h0000, "reset outputs");
		$display("test reset done");
		// Every mode: select, read strobe, then stop
		foreach (modes[k]) begin
			c = modes[k];
			host.wr(tpsf_pkg::OFS_CTRL, c);
			fx <= 16'($urandom()); fy <= 16'($urandom()); tx <= 16'($urandom());
			ty <= 16'($urandom()); tv <= 16'($urandom());
			path_chk(1'b1, c[1]);
			host.rd(tpsf_pkg::OFS_PATH, rv);
			chk(16'(rv), 16'(c), "path status");
			host.pulse();
			path_chk(!c[2], c[1]);
			if (c[2]) m_flags = 16;
			host.rd(tpsf_pkg::OFS_FLAG, rv);
			chk(16'(rv), 16'(m_flags), "return flag");
			host.wr(tpsf_pkg::OFS_FLAG, 8'h1F);
			m_flags = 0;
			host.wr(tpsf_pkg::OFS_CTRL, 8'h00);
			path_chk(1'b0, 1'b0);
		end
		$display("test modes done");
		// Direct switches between modes, then a reset in the middle of a run
		host.wr(tpsf_pkg::OFS_CTRL, 8'h05);
		host.wr(tpsf_pkg::OFS_CTRL, 8'h01);
		host.pulse();
		path_chk(1'b1, 1'b0);
		host.wr(tpsf_pkg::OFS_CTRL, 8'h05);
		host.pulse();
		path_chk(1'b0, 1'b0);
		host.rd(tpsf_pkg::OFS_FLAG, rv);
		chk(16'(rv), 16'(1 << tpsf_pkg::FLG_RETURN), "switched return");
		host.wr(tpsf_pkg::OFS_MASK, 8'(1 << tpsf_pkg::FLG_RETURN));
		#1;
		chk(16'(irq), 16'h0001, "return irq");
		host.wr(tpsf_pkg::OFS_CTRL, 8'h01);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(16'({alt, irq, rdata}), 16'h0000, "reset outputs mid-run");
		chk(ox, 16'h0000, "reset out_x mid-run");
		@(posedge clk);
		sys_rst <= 1'b0;
		path_chk(1'b0, 1'b0);
		host.rd(tpsf_pkg::OFS_FLAG, rv);
		chk(16'(rv), 16'h0000, "flags after reset");
		$display("test switches done");
		// Each fault source: short spike, then a lasting fault
		for (int i = 0; i < 6; i++) begin
			b = (i < 3) ? i : 3;
			m_mask = (i % 2 == 0) ? 31 : 0;
			host.wr(tpsf_pkg::OFS_MASK, 8'(m_mask));
			len = 100 + int'($urandom() % 120);
			cmp[i] <= 1'b1;
			repeat (len) @(posedge clk);
			cmp[i] <= 1'b0;
			repeat (10) @(posedge clk);
			#1;
			chk(16'({sup, rov}), 16'h0000, "spike ignored");
			@(posedge clk);
			cmp[i] <= 1'b1;
			n = 0;
			while ({sup, rov} === 4'h0 && n < 400) begin
				@(posedge clk);
				#1;
				n++;
			end
			if (n == 400) begin
				bad_count++;
				wrap_up();
			end
			chk(16'(n >= 256 && n <= 266), 16'h0001, "filter delay");
			m_flags = m_flags | (1 << b);
			chk(16'({sup, rov}), 16'(m_flags), "flag set");
			chk(16'(irq), 16'((m_flags & m_mask) != 0), "irq level");
			host.rd(tpsf_pkg::OFS_RAW, rv);
			chk(16'(rv), 16'(1 << i), "raw level");
			@(posedge clk);
			cmp[i] <= 1'b0;
			repeat (10) @(posedge clk);
			host.rd(tpsf_pkg::OFS_FLAG, rv);
			chk(16'(rv), 16'(m_flags), "flag sticky");
			host.wr(tpsf_pkg::OFS_FLAG, 8'(1 << b));
			m_flags = 0;
			host.rd(tpsf_pkg::OFS_FLAG, rv);
			chk(16'({rv, 7'h00, irq}), 16'h0000, "flag cleared");
		end
		$display("test faults done");
		wrap_up();
	end
endmodule
